// File: logic/lmic_link_cfg.sv
// Indication reporting and link configuration register for the link
// management channel of a multi-channel frame relay controller.
// Assumes event inputs are one-cycle pulses synchronous to clk_i and a
// host on a plain register port with read data one cycle after the strobe.
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/10ps
`include "lmic_params.svh"

module lmic_link_cfg
  import lmic_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [1:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [15:0] reg_rdata_o,
  // Link management events
  input wire logic poll_tmr_exp_i,
  input wire logic verif_tmr_exp_i,
  input wire logic fs_ovf_i,
  input wire logic fs_sent_i,
  input wire logic [7:0] fs_sent_seq_i,
  input wire logic enq_rx_i,
  input wire logic [7:0] enq_rx_seq_i,
  input wire logic lmi_tx_done_i,
  input wire logic lmi_rx_i,
  input wire logic [3:0] lmi_rx_type_i,
  input wire logic async_rx_i,
  // Received frame header
  input wire logic rx_hdr_valid_i,
  input wire logic [12:0] rx_dlci_i,
  // Indication outputs
  output logic [3:0] ind_code_o,
  output logic [3:0] ind_param_o,
  output logic ind_avail_o,
  output logic ind_lost_o,
  // Received LMI frame handling
  output logic lmi_store_o,
  output logic lmi_strip_hdr_o,
  output logic lmi_drop_o,
  // Received frame classification
  output logic rx_accept_o,
  output logic rx_is_lmi_o,
  output logic rx_use_first_ctx_o,
  // Configuration outputs
  output logic [2:0] dma_cycle_len_o,
  output logic ext_init_o,
  output logic transparent_tx_o,
  output logic annex_d_o,
  output logic poll_all_o,
  output logic [23:0] init_addr_o
);

  // --------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------
  logic [15:0] link_configuration;
  logic [15:0] init_addr_lo;
  lmic_ind_t ind;
  logic [3:0] ind_code;
  logic [3:0] ind_param;
  logic ind_avail;
  logic ind_lost;
  lmic_req_t req;
  lmic_rx_hdr_t hdr;
  logic [4:0] pend;
  // Zero until the first full status frame goes out, so an enquiry that
  // carries zero before then still reports a match
  logic [7:0] last_fs_seq;
  logic [4:0] next_pend;
  logic [4:0] ev_now;
  logic frame_ev;
  logic ack_avail;
  logic ack_lost;
  logic [2:0] pick;
  logic pick_ok;
  logic [12:0] lmi_dlci;
  logic frame_lost;
  logic post_async;
  logic post_rx;
  logic post_ev;
  logic hdr_in_range;
  logic hdr_is_lmi;

  // Register port and received header travel in their carriers
  assign req = {reg_addr_i, reg_wdata_i, reg_we_i, reg_re_i};
  assign hdr = {rx_hdr_valid_i, rx_dlci_i};
  assign ack_avail = req.we && req.addr == `LMIC_OFS_IND &&
                     req.wdata[`LMIC_IND_AVAIL];
  assign ack_lost = req.we && req.addr == `LMIC_OFS_IND &&
                    req.wdata[`LMIC_IND_LOST];
  assign frame_ev = lmi_rx_i | async_rx_i;

  // --------------------------------------------------------------------
  // Configuration writes
  // --------------------------------------------------------------------
  // Reserved bit is masked so it always reads back zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link_configuration <= `LMIC_CFG_RESET;
    end else if (reg_we_i && reg_addr_i == `LMIC_OFS_CFG) begin
      link_configuration <= reg_wdata_i & `LMIC_CFG_WMASK;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      init_addr_lo <= `LMIC_INIT_LO_RESET;
    end else if (reg_we_i && reg_addr_i == `LMIC_OFS_INIT_LO) begin
      // Word alignment is enforced here; bit 0 forced low
      init_addr_lo <= {reg_wdata_i[15:1], 1'b0};
    end
  end

  // --------------------------------------------------------------------
  // Sequence tracking for the new-bit clear indication
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_fs_seq <= 8'h00;
    end else if (fs_sent_i) begin
      last_fs_seq <= fs_sent_seq_i;
    end
  end

  // --------------------------------------------------------------------
  // Pending events
  // --------------------------------------------------------------------
  // Events that meet a busy indication wait here rather than overwrite
  // it; frames cannot wait since their buffers are reused.
  always_comb begin
    ev_now = 5'h00;
    ev_now[LMIC_EV_POLL] = poll_tmr_exp_i;
    ev_now[LMIC_EV_VERIF] = verif_tmr_exp_i;
    ev_now[LMIC_EV_OVF] = fs_ovf_i;
    ev_now[LMIC_EV_SEQ] = enq_rx_i && enq_rx_seq_i == last_fs_seq;
    ev_now[LMIC_EV_TX] = lmi_tx_done_i;
  end

  always_comb begin
    pick = 3'h0;
    pick_ok = 1'b0;
    for (int i = 4; i >= 0; i--) begin
      if (pend[i] | ev_now[i]) begin
        pick = 3'(i);
        pick_ok = 1'b1;
      end
    end
  end

  always_comb begin
    next_pend = pend | ev_now;
    if (!ind.avail && !frame_ev && pick_ok) begin
      next_pend[pick] = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend <= 5'h00;
    end else begin
      pend <= next_pend;
    end
  end

  // --------------------------------------------------------------------
  // Indication register
  // --------------------------------------------------------------------
  // Frames outrank queued events: their buffers are reused at once, so a
  // frame that finds the slot free takes it in that same cycle.
  assign ind = {ind_lost, ind_avail, ind_param, ind_code};
  assign frame_lost = frame_ev && ind_avail;
  assign post_async = !ind_avail && async_rx_i;
  assign post_rx = !ind_avail && !async_rx_i && lmi_rx_i;
  assign post_ev = !ind_avail && !frame_ev && pick_ok;

  // The host clears the flag by writing a one; a posting needs it clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ind_avail <= 1'b0;
    end else if (post_async || post_rx || post_ev) begin
      ind_avail <= 1'b1;
    end else if (ack_avail) begin
      ind_avail <= 1'b0;
    end
  end

  // A new lost frame wins over the host clearing the flag
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ind_lost <= 1'b0;
    end else if (frame_lost) begin
      ind_lost <= 1'b1;
    end else if (ack_lost) begin
      ind_lost <= 1'b0;
    end
  end

  // Code and parameter move only while the slot is free
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ind_code <= 4'h0;
      ind_param <= 4'h0;
    end else if (post_async) begin
      ind_code <= `LMIC_CODE_ASYNC_RX;
      ind_param <= 4'h0;
    end else if (post_rx) begin
      ind_code <= `LMIC_CODE_LMI_RX;
      ind_param <= lmi_rx_type_i;
    end else if (post_ev) begin
      ind_code <= `LMIC_CODE_POLL_TMR + 4'(pick);
      ind_param <= 4'h0;
    end
  end

  // --------------------------------------------------------------------
  // Frame handling pulses
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lmi_store_o <= 1'b0;
      lmi_strip_hdr_o <= 1'b0;
      lmi_drop_o <= 1'b0;
    end else begin
      // Drop pulse tells the counters to stay still
      lmi_drop_o <= frame_ev && ind.avail;
      lmi_store_o <= frame_ev && !ind.avail;
      lmi_strip_hdr_o <= async_rx_i && !ind.avail;
    end
  end

  // --------------------------------------------------------------------
  // Received header classification
  // --------------------------------------------------------------------
  assign lmi_dlci = link_configuration[`LMIC_CFG_LMI_CHAN] ?
                    `LMIC_DLCI_LMI_HIGH : `LMIC_DLCI_LMI_LOW;
  assign hdr_in_range = link_configuration[`LMIC_CFG_WIDE_DLCI] ||
                        hdr.dlci <= `LMIC_DLCI_NARROW_MAX;
  assign hdr_is_lmi = hdr.valid && hdr.dlci == lmi_dlci;

  // The range filter gates acceptance only; DLCI 1023 is always in range
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_accept_o <= 1'b0;
    end else begin
      rx_accept_o <= hdr.valid && hdr_in_range;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_is_lmi_o <= 1'b0;
    end else begin
      rx_is_lmi_o <= hdr_is_lmi;
    end
  end

  // LMI traffic maps to the first context entry on either DLCI
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_use_first_ctx_o <= 1'b0;
    end else begin
      rx_use_first_ctx_o <= hdr_is_lmi;
    end
  end

  // --------------------------------------------------------------------
  // Configuration outputs
  // --------------------------------------------------------------------
  // One cycle behind the register so that every output leaves a flop
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dma_cycle_len_o <= `LMIC_DMA_CYC_LONG;
      ext_init_o <= 1'b0;
      transparent_tx_o <= 1'b0;
      annex_d_o <= 1'b0;
      poll_all_o <= 1'b0;
      init_addr_o <= 24'h000000;
    end else begin
      dma_cycle_len_o <= link_configuration[`LMIC_CFG_SHORT_CYCLE] ?
                         `LMIC_DMA_CYC_SHORT : `LMIC_DMA_CYC_LONG;
      ext_init_o <= link_configuration[`LMIC_CFG_EXT_INIT];
      transparent_tx_o <= link_configuration[`LMIC_CFG_TRANSP];
      annex_d_o <= link_configuration[`LMIC_CFG_ANNEX_D];
      poll_all_o <= link_configuration[`LMIC_CFG_TX_DEMAND];
      init_addr_o <= {link_configuration[`LMIC_CFG_ADDR_HI_MSB:0],
                      init_addr_lo};
    end
  end

  // --------------------------------------------------------------------
  // Register reads and indication outputs
  // --------------------------------------------------------------------
  // Read data fall back to zero after one cycle, so a late sample sees a
  // plain zero rather than a stale word
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_re_i) begin
      unique case (reg_addr_i)
        `LMIC_OFS_IND: reg_rdata_o <= {6'h00, ind};
        `LMIC_OFS_INIT_LO: reg_rdata_o <= init_addr_lo;
        `LMIC_OFS_CFG: reg_rdata_o <= link_configuration;
        default: reg_rdata_o <= 16'h0000;
      endcase
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

  assign ind_code_o = ind.code;
  assign ind_param_o = ind.param;
  assign ind_avail_o = ind.avail;
  assign ind_lost_o = ind.lost;

endmodule

// File: pkg/lmic_params.svh
// Constants for the link management indication and link configuration
// block: register offsets, field positions, reset values, codes, counts.
// Included by the package; holds definitions only.
`ifndef LMIC_PARAMS_SVH
`define LMIC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets (word index on the register port)
// ----------------------------------------------------------------------
`define LMIC_OFS_IND 2'h0
`define LMIC_OFS_INIT_LO 2'h1
`define LMIC_OFS_CFG 2'h2

// ----------------------------------------------------------------------
// Link configuration fields
// ----------------------------------------------------------------------
`define LMIC_CFG_SHORT_CYCLE 15
`define LMIC_CFG_EXT_INIT 14
`define LMIC_CFG_WIDE_DLCI 13
`define LMIC_CFG_LMI_CHAN 12
`define LMIC_CFG_TRANSP 11
`define LMIC_CFG_RSVD 10
`define LMIC_CFG_ANNEX_D 9
`define LMIC_CFG_TX_DEMAND 8
`define LMIC_CFG_ADDR_HI_MSB 7
`define LMIC_CFG_WMASK 16'hFBFF
`define LMIC_CFG_RESET 16'h0000
`define LMIC_INIT_LO_RESET 16'h0000

// ----------------------------------------------------------------------
// Indication register fields
// ----------------------------------------------------------------------
`define LMIC_IND_AVAIL 8
`define LMIC_IND_LOST 9

// ----------------------------------------------------------------------
// Indication codes
// ----------------------------------------------------------------------
`define LMIC_CODE_POLL_TMR 4'h8
`define LMIC_CODE_VERIF_TMR 4'h9
`define LMIC_CODE_FS_OVF 4'hA
`define LMIC_CODE_SEQ_MATCH 4'hB
`define LMIC_CODE_LMI_TX 4'hC
`define LMIC_CODE_LMI_RX 4'hD
`define LMIC_CODE_ASYNC_RX 4'hE

// ----------------------------------------------------------------------
// DLCI limits and DMA cycle lengths in system clocks
// ----------------------------------------------------------------------
`define LMIC_DLCI_NARROW_MAX 13'h03FF
`define LMIC_DLCI_LMI_LOW 13'h0000
`define LMIC_DLCI_LMI_HIGH 13'h03FF
`define LMIC_DMA_CYC_LONG 3'h6
`define LMIC_DMA_CYC_SHORT 3'h5

`endif

// File: pkg/lmic_pkg.sv
// Types for the link management indication and link configuration block.
// Assumes lmic_params.svh is on the include path.
`include "lmic_params.svh"

package lmic_pkg;

  // Pending indication as the host sees it
  typedef struct packed {
    logic lost;
    logic avail;
    logic [3:0] param;
    logic [3:0] code;
  } lmic_ind_t;

  // Register port request
  typedef struct packed {
    logic [1:0] addr;
    logic [15:0] wdata;
    logic we;
    logic re;
  } lmic_req_t;

  // Received frame header as presented by the receiver
  typedef struct packed {
    logic valid;
    logic [12:0] dlci;
  } lmic_rx_hdr_t;

  // Event sources for indications, index 0 is code 8
  typedef enum logic [2:0] {
    LMIC_EV_POLL = 3'h0,
    LMIC_EV_VERIF = 3'h1,
    LMIC_EV_OVF = 3'h2,
    LMIC_EV_SEQ = 3'h3,
    LMIC_EV_TX = 3'h4
  } lmic_ev_t;

endpackage

// File: test/lmi_indication_and_link_config_test.sv
// Self-checking bench for the indication and configuration block.
// Assumes the host model drives the register port.
`timescale 1ns/10ps
module lmi_indication_and_link_config_test;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] ev = 8'h00;
  logic [7:0] sq = 8'h00;
  logic hv = 1'b0;
  logic [12:0] dlci = 13'h0000;
  logic [1:0] ra;
  logic [15:0] rw, rdata, d;
  logic rwe, rre, avail, lost, store, strip, drop, acc, lmi, ctx;
  logic ext, trn, anx, pall;
  logic [3:0] code, param;
  logic [2:0] dma;
  logic [23:0] iaddr;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  always #2 clk_i = ~clk_i;
  lmic_host_model host (.clk_i(clk_i), .reg_addr_o(ra), .reg_wdata_o(rw),
    .reg_we_o(rwe), .reg_re_o(rre), .reg_rdata_i(rdata));
  lmic_link_cfg dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(ra),
    .reg_wdata_i(rw), .reg_we_i(rwe), .reg_re_i(rre), .reg_rdata_o(rdata),
    .poll_tmr_exp_i(ev[0]), .verif_tmr_exp_i(ev[1]), .fs_ovf_i(ev[2]),
    .enq_rx_i(ev[3]), .lmi_tx_done_i(ev[4]), .lmi_rx_i(ev[5]),
    .async_rx_i(ev[6]), .fs_sent_i(ev[7]), .fs_sent_seq_i(sq),
    .enq_rx_seq_i(sq), .lmi_rx_type_i(sq[3:0]), .rx_hdr_valid_i(hv),
    .rx_dlci_i(dlci), .ind_code_o(code), .ind_param_o(param),
    .ind_avail_o(avail), .ind_lost_o(lost), .lmi_store_o(store),
    .lmi_strip_hdr_o(strip), .lmi_drop_o(drop), .rx_accept_o(acc),
    .rx_is_lmi_o(lmi), .rx_use_first_ctx_o(ctx), .dma_cycle_len_o(dma),
    .ext_init_o(ext), .transparent_tx_o(trn), .annex_d_o(anx),
    .poll_all_o(pall), .init_addr_o(iaddr));
  // ------------
  // Shared tasks
  // ------------
  task close_out;
    if (n_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [8:0] st();
    return {drop, strip, store, lost, avail, code};
  endfunction
  task pulse(input logic [7:0] m, input logic [7:0] s);
    @(posedge clk_i);
    ev <= m;
    sq <= s;
    @(posedge clk_i);
    ev <= 8'h00;
    #1;
  endtask
  task ack;
    host.wr(2'h0, 16'h0300);
    #1;
  endtask
  task hdr(input logic [12:0] n, input logic [2:0] e);
    @(posedge clk_i);
    hv <= 1'b1;
    dlci <= n;
    @(posedge clk_i);
    hv <= 1'b0;
    #1;
    chk({acc, lmi, ctx}, e);
  endtask
  // ------------
  // Scenarios
  // ------------
  task t_codes;
    pulse(8'h80, 8'h5A);
    pulse(8'h08, 8'h5B);
    chk(st(), 9'h000);
    for (int i = 0; i < 5; i++) begin
      pulse(8'h01 << i, 8'h5A);
      chk(st(), {5'b00001, 4'h8 + 4'(i)});
      ack;
    end
  endtask
  task t_pend;
    pulse(8'h01, 8'h00);
    pulse(8'h02, 8'h00);
    chk(st(), 9'h018);
    ack;
    chk(st(), 9'h008);
    @(posedge clk_i);
    #1;
    chk(st(), 9'h019);
    ack;
  endtask
  task t_frames;
    pulse(8'h20, 8'h03);
    chk({param, st()}, 13'h065D);
    // Host learns the frame type here; a full status enquiry it answers
    // itself with a full status request, outside this block
    host.rd(2'h0, d);
    chk(d, 16'h013D);
    pulse(8'h40, 8'h00);
    chk(st(), 9'h13D);
    ack;
    chk(st(), 9'h00D);
    pulse(8'h40, 8'h00);
    chk({param, st()}, 13'h00DE);
    ack;
  endtask
  task t_cfg;
    host.wr(2'h2, 16'hFFFF);
    @(posedge clk_i);
    #1;
    chk({dma, ext, trn, anx, pall, iaddr[23:16]}, 15'h5FFF);
    host.wr(2'h1, 16'h1235);
    @(posedge clk_i);
    #1;
    chk({pall, iaddr}, 25'h1FF1234);
    host.rd(2'h2, d);
    chk(d, 16'hFBFF);
    host.wr(2'h3, 16'hFFFF);
    host.rd(2'h3, d);
    chk(d, 16'h0000);
    host.wr(2'h2, 16'h0000);
    @(posedge clk_i);
    #1;
    chk({dma, ext, trn, anx, pall, iaddr[23:16]}, 15'h6000);
  endtask
  task t_dlci;
    hdr(13'h0000, 3'b111);
    hdr(13'h03FF, 3'b100);
    hdr(13'h0400, 3'b000);
    host.wr(2'h2, 16'h3000);
    hdr(13'h03FF, 3'b111);
    hdr(13'h0000, 3'b100);
    hdr(13'h1FFF, 3'b100);
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1;
    chk({dma, st()}, 12'hC00);
    t_codes();
    t_pend();
    t_frames();
    t_cfg();
    t_dlci();
    close_out();
  end
endmodule

// File: test/lmic_host_model.sv
// Host model: register master that acknowledges and configures.
// Assumes read data stand in the cycle after the read strobe.
`timescale 1ns/10ps
module lmic_host_model (
  // Clock
  input wire logic clk_i,
  // Register port
  output logic [1:0] reg_addr_o,
  output logic [15:0] reg_wdata_o,
  output logic reg_we_o,
  output logic reg_re_o,
  input wire logic [15:0] reg_rdata_i
);
  initial begin
    reg_addr_o = 2'h0;
    reg_wdata_o = 16'h0000;
    reg_we_o = 1'b0;
    reg_re_o = 1'b0;
  end
  // ------------
  // Bus cycles
  // ------------
  // Released data shows its inverse, so a stale copy cannot pass
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    logic [15:0] v;
    v = (a == 2'h2) ? (d & 16'hFBFF) : d;
    v[0] = v[0] & (a != 2'h1);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= v;
    reg_we_o <= 1'b1;
    @(posedge clk_i);
    reg_we_o <= 1'b0;
    reg_wdata_o <= ~v;
  endtask
  task automatic rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_re_o <= 1'b1;
    @(posedge clk_i);
    reg_re_o <= 1'b0;
    #1;
    d = reg_rdata_i;
  endtask
endmodule

// File: test/lmic_link_cfg_checker.sv
// Checker for the indication and link configuration block.
// Assumes it sees only the block's ports, bound below.
`timescale 1ns/10ps
module lmic_link_cfg_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Block inputs
  input wire logic [1:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic poll_tmr_exp_i,
  input wire logic verif_tmr_exp_i,
  input wire logic fs_ovf_i,
  input wire logic enq_rx_i,
  input wire logic lmi_tx_done_i,
  input wire logic lmi_rx_i,
  input wire logic [3:0] lmi_rx_type_i,
  input wire logic async_rx_i,
  input wire logic rx_hdr_valid_i,
  input wire logic [12:0] rx_dlci_i,
  // Block outputs
  input wire logic [3:0] ind_code_o,
  input wire logic [3:0] ind_param_o,
  input wire logic ind_avail_o,
  input wire logic ind_lost_o,
  input wire logic lmi_store_o,
  input wire logic lmi_strip_hdr_o,
  input wire logic lmi_drop_o,
  input wire logic rx_accept_o,
  input wire logic rx_is_lmi_o,
  input wire logic rx_use_first_ctx_o,
  input wire logic [2:0] dma_cycle_len_o,
  input wire logic ext_init_o,
  input wire logic transparent_tx_o,
  input wire logic annex_d_o,
  input wire logic poll_all_o,
  input wire logic [23:0] init_addr_o
);
  logic [15:0] w1;
  logic [15:0] w2;
  logic frame;
  logic any_ev;
  assign frame = lmi_rx_i | async_rx_i;
  assign any_ev = frame | poll_tmr_exp_i | verif_tmr_exp_i | fs_ovf_i
    | enq_rx_i;
  // Write data delayed to line up with the lag of the config outputs
  always_ff @(posedge clk_i) begin
    w1 <= reg_wdata_i;
    w2 <= w1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ------------
  // Assertions
  // ------------
  poll_post_a: assert property (
    !ind_avail_o && poll_tmr_exp_i && !frame |=>
    ind_avail_o && ind_code_o == 4'h8) else $error("poll code wrong");
  tx_post_a: assert property (
    !ind_avail_o && !$past(ind_avail_o) && lmi_tx_done_i && !any_ev |=>
    ind_avail_o && ind_code_o == 4'hC) else $error("tx code wrong");
  rx_post_a: assert property (
    !ind_avail_o && lmi_rx_i && !async_rx_i |=> ind_code_o == 4'hD &&
    ind_param_o == $past(lmi_rx_type_i) && lmi_store_o)
    else $error("rx frame post wrong");
  async_post_a: assert property (
    !ind_avail_o && async_rx_i |=> ind_avail_o && ind_code_o == 4'hE &&
    lmi_store_o && lmi_strip_hdr_o) else $error("async post wrong");
  frame_lost_a: assert property (
    ind_avail_o && frame |=> ind_lost_o && lmi_drop_o && !lmi_store_o &&
    $stable(ind_code_o)) else $error("lost frame not flagged");
  ind_hold_a: assert property (
    ind_avail_o && !(reg_we_i && reg_addr_i == 2'h0 && reg_wdata_i[8])
    |=> ind_avail_o && $stable({ind_code_o, ind_param_o}))
    else $error("pending code not held");
  cfg_out_a: assert property (
    reg_we_i && reg_addr_i == 2'h2 |=> ##1 {dma_cycle_len_o, ext_init_o,
    transparent_tx_o, annex_d_o, poll_all_o, init_addr_o[23:16]} ==
    {w2[15] ? 3'h5 : 3'h6, w2[14], w2[11], w2[9:0]})
    else $error("config outputs wrong");
  hdr_class_a: assert property (
    rx_hdr_valid_i |=> rx_use_first_ctx_o == rx_is_lmi_o &&
    (!rx_is_lmi_o || $past(rx_dlci_i) inside {13'h0000, 13'h03FF}) &&
    ($past(rx_dlci_i) > 13'h03FF || rx_accept_o))
    else $error("header class wrong");
endmodule

bind lmic_link_cfg lmic_link_cfg_checker u_chk (.*);
